// *** dph_pkg.sv ***
// Operation
// - Every register write gets a fresh physical register
// - WAW pair maps to later writer
// - Operand forward: one read feeds both
// - Operand forward only after move-type first
// - Operand forward from register or memory
// - Operand forward needs matching operand sizes
// - Result forward: one result, two destinations
// - Result forward only when second is move
// - Memory result forward skips register read-back
// - Store data bypassed to following load
// - Bypass only for cacheable addresses
// - Bypass stalls secondary pipe exactly one clock
// - Thirty-two physical registers, any architectural use
// - Exceptions and memory writes in program order
package dph_pkg;
    // Pool and architectural sizes
    localparam int PHYS_REGS = 32;
    localparam int PHYS_W = 5;
    localparam int ARCH_REGS = 8;
    localparam int ARCH_W = 3;
    localparam int INFL_W = 3;
    // Operation classes from decode
    localparam logic [1:0] OP_MOVE = 2'h0;
    localparam logic [1:0] OP_ALU = 2'h1;
    localparam logic [1:0] OP_OTHER = 2'h2;
    // Bypass stall length in clocks
    localparam logic [1:0] BYP_STALL_CYC = 2'h1;
    // Forwarding decision codes
    localparam logic [2:0] FW_NONE = 3'h0;
    localparam logic [2:0] FW_OPERAND = 3'h1;
    localparam logic [2:0] FW_RESULT = 3'h2;
    localparam logic [2:0] FW_BYPASS = 3'h3;
    localparam logic [2:0] FW_INTERLOCK = 3'h4;
endpackage

// *** dph_free_pool.sv ***
`timescale 1ns/1ps
// Free list of physical registers with reference counts
module dph_free_pool #(
    parameter int NREG = dph_pkg::PHYS_REGS
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Allocation requests, two per clock
    input wire logic alloc0_i,
    input wire logic alloc1_i,
    output logic [dph_pkg::PHYS_W-1:0] grant0_o,
    output logic [dph_pkg::PHYS_W-1:0] grant1_o,
    output logic avail_o,
    // Reference events
    input wire logic [NREG-1:0] unmap_i,
    input wire logic [NREG-1:0] retire_i
);
    // Architectural mapping held
    logic [NREG-1:0] mapped_r;
    logic [NREG-1:0] mapped_nxt;
    // In-flight writer outstanding
    logic [NREG-1:0] busy_r;
    logic [NREG-1:0] busy_nxt;
    logic [NREG-1:0] used;
    logic [NREG-1:0] take;
    logic found0;
    logic found1;

    // Pick two lowest free entries
    always_comb
    begin
        grant0_o = '0;
        grant1_o = '0;
        found0 = 1'b0;
        found1 = 1'b0;
        for (int i = 0; i < NREG; i++)
        begin
            if (!used[i] && !found0)
            begin
                grant0_o = i[dph_pkg::PHYS_W-1:0];
                found0 = 1'b1;
            end
            else if (!used[i] && !found1)
            begin
                grant1_o = i[dph_pkg::PHYS_W-1:0];
                found1 = 1'b1;
            end
        end
        avail_o = found0 && found1;
    end

    // Per-entry reference bookkeeping
    generate
        for (genvar g = 0; g < NREG; g++)
        begin : g_ent
            assign used[g] = mapped_r[g] || busy_r[g];
            assign take[g] = avail_o && ((alloc0_i && grant0_o == g) ||
                                         (alloc1_i && grant1_o == g));
            always_comb
            begin
                // Granted and unmapped at once: the overridden WAW writer never maps
                mapped_nxt[g] = (take[g] || mapped_r[g]) && !unmap_i[g];
                // Allocation wins over a release in the same clock
                busy_nxt[g] = take[g] || (busy_r[g] && !retire_i[g]);
            end
        end
    endgenerate

    // Entries 0..7 start mapped to the architectural registers
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mapped_r <= 32'h0000_00FF;
            busy_r <= '0;
        end
        else
        begin
            mapped_r <= mapped_nxt;
            busy_r <= busy_nxt;
        end
    end

    pool_free_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (alloc0_i && avail_o) |-> !used[grant0_o])
        else $error("Allocated register still referenced");
    pool_split_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        avail_o |-> grant0_o != grant1_o)
        else $error("Same register granted twice");
endmodule

// *** dph_pair_check.sv ***
`timescale 1ns/1ps
// Combinational classification of an issued pair
module dph_pair_check (
    // First (primary) instruction
    input wire logic [1:0] p_class_i,
    input wire logic p_wr_reg_i,
    input wire logic [dph_pkg::ARCH_W-1:0] p_dst_i,
    input wire logic [1:0] p_dst_size_i,
    input wire logic p_mem_wr_i,
    input wire logic [31:0] p_addr_i,
    input wire logic p_cacheable_i,
    // Second (secondary) instruction
    input wire logic [1:0] s_class_i,
    input wire logic s_rd_reg_i,
    input wire logic [dph_pkg::ARCH_W-1:0] s_src_i,
    input wire logic [1:0] s_src_size_i,
    input wire logic s_mem_rd_i,
    input wire logic [31:0] s_addr_i,
    // Decision
    output logic [2:0] kind_o
);
    logic reg_raw;
    logic mem_raw;

    // Classify dependency, forwarding first
    always_comb
    begin
        reg_raw = p_wr_reg_i && s_rd_reg_i && (p_dst_i == s_src_i);
        mem_raw = p_mem_wr_i && s_mem_rd_i && (p_addr_i == s_addr_i);
        kind_o = dph_pkg::FW_NONE;
        if (reg_raw)
        begin
            if (p_class_i == dph_pkg::OP_MOVE && p_dst_size_i == s_src_size_i)
                kind_o = dph_pkg::FW_OPERAND;
            else if (p_class_i == dph_pkg::OP_ALU && s_class_i == dph_pkg::OP_MOVE)
                kind_o = dph_pkg::FW_RESULT;
            else
                kind_o = dph_pkg::FW_INTERLOCK;
        end
        else if (mem_raw)
        begin
            // Non-cacheable load must truly read memory
            kind_o = p_cacheable_i ? dph_pkg::FW_BYPASS : dph_pkg::FW_INTERLOCK;
        end
    end
endmodule

// *** dph_hazard_resolver.sv ***
`timescale 1ns/1ps
// Rename map and pair dependency control for the two pipes
module dph_hazard_resolver (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Pair issue handshake
    input wire logic pair_valid_i,
    output logic pair_accept_o,
    // Primary instruction
    input wire logic [1:0] p_class_i,
    input wire logic p_wr_reg_i,
    input wire logic [2:0] p_dst_i,
    input wire logic [1:0] p_dst_size_i,
    input wire logic [2:0] p_src_i,
    input wire logic p_mem_wr_i,
    input wire logic [31:0] p_addr_i,
    input wire logic p_cacheable_i,
    input wire logic p_exc_i,
    // Secondary instruction
    input wire logic s_valid_i,
    input wire logic [1:0] s_class_i,
    input wire logic s_wr_reg_i,
    input wire logic [2:0] s_dst_i,
    input wire logic s_rd_reg_i,
    input wire logic [2:0] s_src_i,
    input wire logic [1:0] s_src_size_i,
    input wire logic s_mem_rd_i,
    input wire logic s_mem_wr_i,
    input wire logic [31:0] s_addr_i,
    input wire logic s_exc_i,
    // Primary result available (interlock release)
    input wire logic p_done_i,
    input wire logic [4:0] p_done_tag_i,
    // Secondary retire
    input wire logic s_done_i,
    input wire logic [4:0] s_done_tag_i,
    // Store data from primary
    input wire logic [31:0] p_store_data_i,
    // Rename results
    output logic [4:0] p_phys_dst_o,
    output logic [4:0] s_phys_dst_o,
    output logic [4:0] p_phys_src_o,
    output logic [4:0] s_phys_src_o,
    // Forwarding controls
    output logic [2:0] fwd_kind_o,
    output logic s_mem_wr_from_result_o,
    output logic s_stall_o,
    output logic [31:0] s_bypass_data_o,
    output logic s_bypass_valid_o,
    // Ordered side effects
    output logic mem_wr_slot0_s_o,
    output logic exc_report_o,
    output logic exc_is_s_o
);
    //////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_s1_r;
    logic rst_n_r;

    // Two-stage release of the async reset
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    //////////////////////////////////////////////////////////////////
    // Pair classification and free pool
    logic [2:0] kind;
    logic [4:0] g0;
    logic [4:0] g1;
    logic avail;
    logic take;
    logic [dph_pkg::PHYS_REGS-1:0] unmap;
    logic [dph_pkg::PHYS_REGS-1:0] retire;
    // Logical to physical map
    logic [4:0] map_r [dph_pkg::ARCH_REGS];
    logic [4:0] map_nxt [dph_pkg::ARCH_REGS];
    // Interlock and bypass stall state
    logic wait_r;
    logic wait_nxt;
    logic [4:0] wait_tag_r;
    logic [4:0] wait_tag_nxt;
    logic [1:0] byp_cnt_r;
    logic [1:0] byp_cnt_nxt;
    logic busy;

    dph_pair_check u_check (
        .p_class_i(p_class_i),
        .p_wr_reg_i(p_wr_reg_i),
        .p_dst_i(p_dst_i),
        .p_dst_size_i(p_dst_size_i),
        .p_mem_wr_i(p_mem_wr_i),
        .p_addr_i(p_addr_i),
        .p_cacheable_i(p_cacheable_i),
        .s_class_i(s_class_i),
        .s_rd_reg_i(s_rd_reg_i && s_valid_i),
        .s_src_i(s_src_i),
        .s_src_size_i(s_src_size_i),
        .s_mem_rd_i(s_mem_rd_i && s_valid_i),
        .s_addr_i(s_addr_i),
        .kind_o(kind)
    );

    dph_free_pool #(
        .NREG(dph_pkg::PHYS_REGS)
    ) u_pool (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_r),
        .alloc0_i(take && p_wr_reg_i),
        .alloc1_i(take && s_valid_i && s_wr_reg_i),
        .grant0_o(g0),
        .grant1_o(g1),
        .avail_o(avail),
        .unmap_i(unmap),
        .retire_i(retire)
    );

    // Pair blocked while an earlier stall is pending or pool is short
    assign busy = wait_r || (byp_cnt_r != 2'h0);
    assign take = pair_valid_i && !busy && avail;

    //////////////////////////////////////////////////////////////////
    // Rename map update and release events
    always_comb
    begin
        unmap = '0;
        retire = '0;
        for (int a = 0; a < dph_pkg::ARCH_REGS; a++)
            map_nxt[a] = map_r[a];
        if (take && p_wr_reg_i)
        begin
            map_nxt[p_dst_i] = g0;
            unmap[map_r[p_dst_i]] = 1'b1;
        end
        if (take && s_valid_i && s_wr_reg_i)
        begin
            // Later writer in program order owns the mapping
            map_nxt[s_dst_i] = g1;
            if (!(p_wr_reg_i && p_dst_i == s_dst_i))
                unmap[map_r[s_dst_i]] = 1'b1;
            else
                unmap[g0] = 1'b1;
        end
        if (p_done_i)
            retire[p_done_tag_i] = 1'b1;
        if (s_done_i)
            retire[s_done_tag_i] = 1'b1;
    end

    // Interlock and bypass stall sequencing
    always_comb
    begin
        wait_nxt = wait_r;
        wait_tag_nxt = wait_tag_r;
        byp_cnt_nxt = (byp_cnt_r != 2'h0) ? byp_cnt_r - 2'h1 : 2'h0;
        // Release when the awaited primary result arrives
        if (wait_r && p_done_i && p_done_tag_i == wait_tag_r)
            wait_nxt = 1'b0;
        if (take && kind == dph_pkg::FW_INTERLOCK)
        begin
            wait_nxt = 1'b1;
            wait_tag_nxt = g0;
        end
        if (take && kind == dph_pkg::FW_BYPASS)
            byp_cnt_nxt = dph_pkg::BYP_STALL_CYC;
    end

    // Map starts as identity onto entries 0..7
    always_ff @(posedge clk_sys_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            for (int a = 0; a < dph_pkg::ARCH_REGS; a++)
                map_r[a] <= 5'(a);
            wait_r <= 1'b0;
            wait_tag_r <= 5'h00;
            byp_cnt_r <= 2'h0;
        end
        else
        begin
            for (int a = 0; a < dph_pkg::ARCH_REGS; a++)
                map_r[a] <= map_nxt[a];
            wait_r <= wait_nxt;
            wait_tag_r <= wait_tag_nxt;
            byp_cnt_r <= byp_cnt_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////
    // Registered outputs toward register file, execute and cache
    logic stall_nxt;
    logic byp_v_nxt;
    always_comb
    begin
        stall_nxt = wait_nxt || (byp_cnt_nxt != 2'h0);
        byp_v_nxt = take && kind == dph_pkg::FW_BYPASS;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            pair_accept_o <= 1'b0;
            p_phys_dst_o <= 5'h00;
            s_phys_dst_o <= 5'h00;
            p_phys_src_o <= 5'h00;
            s_phys_src_o <= 5'h00;
            fwd_kind_o <= 3'h0;
            s_mem_wr_from_result_o <= 1'b0;
            s_stall_o <= 1'b0;
            s_bypass_data_o <= 32'h0000_0000;
            s_bypass_valid_o <= 1'b0;
            mem_wr_slot0_s_o <= 1'b0;
            exc_report_o <= 1'b0;
            exc_is_s_o <= 1'b0;
        end
        else
        begin
            pair_accept_o <= take;
            p_phys_dst_o <= g0;
            s_phys_dst_o <= g1;
            p_phys_src_o <= map_r[p_src_i];
            // Operand forward: secondary shares the primary's source read
            if (kind == dph_pkg::FW_OPERAND)
                s_phys_src_o <= map_r[p_src_i];
            else
                s_phys_src_o <= map_r[s_src_i];
            fwd_kind_o <= take ? kind : dph_pkg::FW_NONE;
            // Store takes ALU result directly, no register read-back
            s_mem_wr_from_result_o <= take && kind == dph_pkg::FW_RESULT
                && s_mem_wr_i;
            s_stall_o <= stall_nxt;
            if (byp_v_nxt)
                s_bypass_data_o <= p_store_data_i;
            s_bypass_valid_o <= byp_v_nxt;
            // Primary store always goes first; flag secondary store in slot 0 when primary has none
            mem_wr_slot0_s_o <= take && s_mem_wr_i && !p_mem_wr_i;
            // Primary exception masks a later secondary one
            exc_report_o <= take && (p_exc_i || (s_valid_i && s_exc_i));
            exc_is_s_o <= take && !p_exc_i && s_valid_i && s_exc_i;
        end
    end

    //////////////////////////////////////////////////////////////////
    // Checks
    byp_one_clk_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
        s_bypass_valid_o |-> s_stall_o ##1 !s_stall_o)
        else $error("Bypass stall not exactly one clock");
    waw_later_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
        (take && p_wr_reg_i && s_valid_i && s_wr_reg_i && p_dst_i == s_dst_i)
        |=> map_r[$past(s_dst_i)] == $past(g1))
        else $error("WAW map not on later writer");
    opf_move_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
        (take && kind == dph_pkg::FW_OPERAND) |->
        p_class_i == dph_pkg::OP_MOVE && p_dst_size_i == s_src_size_i)
        else $error("Operand forward without move or size match");
    res_move_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
        (take && kind == dph_pkg::FW_RESULT) |-> s_class_i == dph_pkg::OP_MOVE)
        else $error("Result forward to non-move");
    byp_data_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
        byp_v_nxt |=> s_bypass_valid_o && s_bypass_data_o == $past(p_store_data_i))
        else $error("Bypass data not the held store data");
    byp_cache_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
        (take && kind == dph_pkg::FW_BYPASS) |-> p_cacheable_i)
        else $error("Bypass on non-cacheable address");
    fresh_dst_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
        (take && p_wr_reg_i) |=> p_phys_dst_o != $past(map_r[p_dst_i]))
        else $error("Write reused mapped register");
    ilk_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
        (wait_r && !p_done_i) |=> s_stall_o && !pair_accept_o)
        else $error("Interlock released early");
    exc_order_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
        (take && p_exc_i) |=> exc_report_o && !exc_is_s_o)
        else $error("Exception out of program order");
    opf_seen_c: cover property (@(posedge clk_sys_i) take && kind == dph_pkg::FW_OPERAND);
    res_seen_c: cover property (@(posedge clk_sys_i) take && kind == dph_pkg::FW_RESULT);
    byp_seen_c: cover property (@(posedge clk_sys_i) take && kind == dph_pkg::FW_BYPASS);
    ilk_seen_c: cover property (@(posedge clk_sys_i) take && kind == dph_pkg::FW_INTERLOCK);
endmodule

// *** dph_exec_model.sv ***
`timescale 1ns/1ps
// Execute stage and retire model on the far side of the resolver
module dph_exec_model (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Answer speed, high for a long execute
    input wire logic slow_i,
    // Pair taken, with its physical destinations
    input wire logic accept_i,
    input wire logic [4:0] p_tag_i,
    input wire logic [4:0] s_tag_i,
    // Completion pulses
    output logic p_done_o,
    output logic [4:0] p_done_tag_o,
    output logic s_done_o,
    output logic [4:0] s_done_tag_o
);
    logic [2:0] cnt; // Cycles left until completion
    logic [4:0] ptag; // Held primary tag
    logic [4:0] stag; // Held secondary tag

    ////////////////////////////////////////////////////////////////////////////
    // One pair in flight; tags wobble while idle so a stale tag never matches
    always @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt <= 3'h0;
            p_done_o <= 1'b0;
            s_done_o <= 1'b0;
            p_done_tag_o <= 5'h15;
            s_done_tag_o <= 5'h0A;
        end
        else
        begin
            p_done_o <= 1'b0;
            s_done_o <= 1'b0;
            p_done_tag_o <= ~p_done_tag_o;
            s_done_tag_o <= ~s_done_tag_o;
            if (accept_i)
            begin
                cnt <= slow_i ? 3'h4 : 3'h1;
                ptag <= p_tag_i;
                stag <= s_tag_i;
            end
            else if (cnt != 3'h0)
            begin
                cnt <= cnt - 3'h1;
                // Result ready: releases interlock and busy state
                if (cnt == 3'h1)
                begin
                    p_done_o <= 1'b1;
                    p_done_tag_o <= ptag;
                    s_done_o <= 1'b1;
                    s_done_tag_o <= stag;
                end
            end
        end
    end
endmodule

// *** dph_hazard_resolver_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench for the pair hazard resolver
module dph_hazard_resolver_tb;
    logic clk_sys_i = 1'b0, arst_n_i = 1'b0, pair_valid_i = 1'b0, pair_accept_o, slow = 1'b0;
    logic [1:0] p_class_i, p_dst_size_i, s_class_i, s_src_size_i;
    logic [2:0] p_dst_i, p_src_i, s_dst_i, s_src_i, fwd_kind_o;
    logic p_wr_reg_i, p_mem_wr_i, p_cacheable_i, p_exc_i, s_valid_i, s_wr_reg_i, s_rd_reg_i;
    logic s_mem_rd_i, s_mem_wr_i, s_exc_i, p_done_i, s_done_i;
    logic [31:0] p_addr_i, s_addr_i, p_store_data_i, s_bypass_data_o;
    logic [4:0] p_done_tag_i, s_done_tag_i, p_phys_dst_o, s_phys_dst_o, p_phys_src_o, s_phys_src_o;
    logic s_mem_wr_from_result_o, s_stall_o, s_bypass_valid_o, mem_wr_slot0_s_o;
    logic exc_report_o, exc_is_s_o;
    int fails = 0;
    int comparisons = 0;

    always #4 clk_sys_i = ~clk_sys_i;

    dph_hazard_resolver dph_hazard_resolver_i (.*);
    dph_exec_model dph_exec_model_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .slow_i(slow), .accept_i(pair_accept_o), .p_tag_i(p_phys_dst_o),
        .s_tag_i(s_phys_dst_o), .p_done_o(p_done_i), .p_done_tag_o(p_done_tag_i),
        .s_done_o(s_done_i), .s_done_tag_o(s_done_tag_i));

    ////////////////////////////////////////////////////////////////////////////
    // Common tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task summarize;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Idle pair fields, both slots present
    task clear;
        {p_class_i, p_dst_size_i, s_class_i, s_src_size_i} = 8'h00;
        {p_dst_i, p_src_i, s_dst_i, s_src_i} = 12'h000;
        {p_wr_reg_i, p_mem_wr_i, p_cacheable_i, p_exc_i} = 4'h0;
        {s_wr_reg_i, s_rd_reg_i, s_mem_rd_i, s_mem_wr_i, s_exc_i} = 5'h00;
        s_valid_i = 1'b1;
        p_addr_i = 32'h0;
        s_addr_i = 32'h0;
        p_store_data_i = 32'h0;
    endtask

    // Offer the pair and return at the falling edge where it is answered
    task go;
        int n;
        n = 0;
        pair_valid_i = 1'b1;
        @(negedge clk_sys_i);
        while (pair_accept_o !== 1'b1 && n < 20)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        pair_valid_i = 1'b0;
        if (n == 20)
        begin
            fails++;
            summarize();
        end
    endtask

    // Wait for the secondary pipe to run again, then let the model go idle
    task settle;
        int n;
        n = 0;
        while (s_stall_o !== 1'b0 && n < 50)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n == 50)
        begin
            fails++;
            summarize();
        end
        repeat (6) @(negedge clk_sys_i);
        clear();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    // Write-after-write pair, then a read of the shared register
    task t_waw;
        p_class_i = dph_pkg::OP_ALU;
        p_wr_reg_i = 1'b1;
        p_src_i = 3'h1;
        s_class_i = dph_pkg::OP_MOVE;
        s_wr_reg_i = 1'b1;
        s_mem_rd_i = 1'b1;
        s_addr_i = 32'h0000_0200;
        go();
        check("waw p dst", p_phys_dst_o, 32'h8);
        check("waw s dst", s_phys_dst_o, 32'h9);
        check("waw stall", s_stall_o, 32'h0);
        settle();
        p_class_i = dph_pkg::OP_MOVE;
        p_wr_reg_i = 1'b1;
        p_dst_i = 3'h3;
        s_class_i = dph_pkg::OP_ALU;
        s_wr_reg_i = 1'b1;
        s_dst_i = 3'h4;
        s_rd_reg_i = 1'b1;
        s_src_i = 3'h5;
        go();
        check("later writer read", p_phys_src_o, 32'h9);
        check("untouched read", s_phys_src_o, 32'h5);
        settle();
        $display("waw test done");
    endtask

    // Move then dependent use, for every secondary source size
    task t_operand;
        for (int sz = 0; sz < 4; sz++)
        begin
            p_class_i = dph_pkg::OP_MOVE;
            p_wr_reg_i = 1'b1;
            p_dst_i = 3'h1;
            p_dst_size_i = 2'h2;
            s_class_i = dph_pkg::OP_ALU;
            s_wr_reg_i = 1'b1;
            s_dst_i = 3'h6;
            s_rd_reg_i = 1'b1;
            s_src_i = 3'h1;
            s_src_size_i = sz[1:0];
            go();
            if (sz == 2)
                check("operand fwd", fwd_kind_o, dph_pkg::FW_OPERAND);
            else
                check("size mismatch", fwd_kind_o, dph_pkg::FW_INTERLOCK);
            check("operand stall", s_stall_o, (sz == 2) ? 32'h0 : 32'h1);
            settle();
        end
        $display("operand test done");
    endtask

    // Computing first instruction cannot forward its operand; slow result
    task t_interlock;
        int n;
        slow = 1'b1;
        p_class_i = dph_pkg::OP_ALU;
        p_wr_reg_i = 1'b1;
        p_dst_i = 3'h2;
        s_class_i = dph_pkg::OP_ALU;
        s_wr_reg_i = 1'b1;
        s_dst_i = 3'h6;
        s_rd_reg_i = 1'b1;
        s_src_i = 3'h2;
        go();
        check("interlock kind", fwd_kind_o, dph_pkg::FW_INTERLOCK);
        n = 0;
        while (s_stall_o === 1'b1 && n < 30)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        check("held until result", n >= 3, 32'h1);
        slow = 1'b0;
        settle();
        $display("interlock test done");
    endtask

    // Result moved to a register, then to memory
    task t_result;
        for (int m = 0; m < 2; m++)
        begin
            p_class_i = dph_pkg::OP_ALU;
            p_wr_reg_i = 1'b1;
            p_dst_i = 3'h2;
            s_class_i = dph_pkg::OP_MOVE;
            s_rd_reg_i = 1'b1;
            s_src_i = 3'h2;
            s_wr_reg_i = (m == 0);
            s_dst_i = 3'h7;
            s_mem_wr_i = (m == 1);
            s_addr_i = 32'h0000_0300;
            go();
            check("result fwd", fwd_kind_o, dph_pkg::FW_RESULT);
            check("store from result", s_mem_wr_from_result_o, m);
            check("result stall", s_stall_o, 32'h0);
            settle();
        end
        $display("result test done");
    endtask

    // Store then load of the same place, cacheable and not
    task t_bypass;
        for (int c = 1; c >= 0; c--)
        begin
            p_class_i = dph_pkg::OP_ALU;
            p_mem_wr_i = 1'b1;
            p_addr_i = 32'h0000_0100;
            p_cacheable_i = c[0];
            p_store_data_i = 32'hA5A5_0001;
            s_class_i = dph_pkg::OP_ALU;
            s_wr_reg_i = 1'b1;
            s_dst_i = 3'h5;
            s_mem_rd_i = 1'b1;
            s_addr_i = 32'h0000_0100;
            go();
            check("bypass valid", s_bypass_valid_o, c);
            if (c == 1)
            begin
                check("bypass kind", fwd_kind_o, dph_pkg::FW_BYPASS);
                check("bypass data", s_bypass_data_o, 32'hA5A5_0001);
                check("bypass stall", s_stall_o, 32'h1);
                @(negedge clk_sys_i);
                check("one clock only", s_stall_o, 32'h0);
            end
            settle();
        end
        $display("bypass test done");
    endtask

    // Exceptions from either slot, secondary-only store
    task t_exc;
        for (int e = 1; e < 4; e++)
        begin
            p_exc_i = e[0];
            s_exc_i = e[1];
            s_mem_wr_i = 1'b1;
            s_addr_i = 32'h0000_0400;
            go();
            check("exc report", exc_report_o, 32'h1);
            check("exc owner", exc_is_s_o, (e == 2));
            check("secondary store", mem_wr_slot0_s_o, 32'h1);
            settle();
        end
        $display("exception test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        clear();
        repeat (6) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        t_waw();
        t_operand();
        t_interlock();
        t_result();
        t_bypass();
        t_exc();
        summarize();
    end
endmodule
